// File: mouse_report_defines.vh
// constants for the pointer motion report serializer
`ifndef MOUSE_REPORT_DEFINES_VH
`define MOUSE_REPORT_DEFINES_VH
`define CLK_HZ 100000000
`define BAUD_RATE 9600
`define BIT_CYCLES (`CLK_HZ / `BAUD_RATE)
`define BIT_CNT_W 14
// bit period counter must hold BIT_CYCLES - 1
`define SYNC_PATTERN 5'h10
`define DELTA_MAX 8'h7F
`define DELTA_MIN 8'h81
`define REPORT_BYTES 5
`endif

// File: uart_byte_tx.v
// eight-n-one serial byte transmitter with ready/valid input
`timescale 1ns/1ns
`include "mouse_report_defines.vh"
module uart_byte_tx #(
	parameter BIT_CYC = `BIT_CYCLES
) (
	input wire ref_clk,
	input wire rst,
	input wire [7:0] tx_data,
	input wire tx_valid,
	output reg tx_ready,
	output reg tx_start,
	output reg serial_out
);
	localparam integer BIT_LAST_I = BIT_CYC - 1;
	localparam [`BIT_CNT_W-1:0] BIT_LAST = BIT_LAST_I[`BIT_CNT_W-1:0];
	reg [`BIT_CNT_W-1:0] baud_reg;
	reg [3:0] bit_idx_reg;
	reg [9:0] shift_reg;
	reg busy_reg;
	always @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			baud_reg <= {`BIT_CNT_W{1'b0}};
			bit_idx_reg <= 4'h0;
			shift_reg <= 10'h3FF;
			busy_reg <= 1'b0;
			tx_ready <= 1'b0;
			tx_start <= 1'b0;
			serial_out <= 1'b1;
		end else begin
			tx_start <= 1'b0;
			if (!busy_reg) begin
				tx_ready <= 1'b1;
				if (tx_valid && tx_ready) begin
					// stop, data lsb first, start
					shift_reg <= {1'b1, tx_data, 1'b0};
					busy_reg <= 1'b1;
					tx_ready <= 1'b0;
					tx_start <= 1'b1;
					baud_reg <= {`BIT_CNT_W{1'b0}};
					bit_idx_reg <= 4'h0;
					serial_out <= 1'b0;
				end
			end else if (baud_reg == BIT_LAST) begin
				baud_reg <= {`BIT_CNT_W{1'b0}};
				if (bit_idx_reg == 4'h9) begin
					busy_reg <= 1'b0;
					serial_out <= 1'b1;
				end else begin
					bit_idx_reg <= bit_idx_reg + 4'h1;
					serial_out <= shift_reg[bit_idx_reg + 4'h1];
				end
			end else begin
				baud_reg <= baud_reg + {{(`BIT_CNT_W-1){1'b0}}, 1'b1};
			end
		end
	end
endmodule

// File: mouse_motion_report_serializer.v
// pointer motion report builder: switches and motion into five-byte serial reports
// How it works
// - the line runs at 9600 baud, one start bit, eight data bits, one stop bit, no parity.
// - data bits go out bit 0 first, bit 7 last.
// - a report is sent only when switches or motion changed since the last report.
// - byte 1 has bit 7 set and bits 6 to 3 clear as a sync marker.
// - switch bits are active low, zero meaning pressed.
// - right switch in bit 0, middle in bit 1, left in bit 2.
// - byte 2 is X motion up to the start of byte 1.
// - motion bytes stay in -127..+127, never -128.
// - rightward motion gives positive X.
// - byte 3 is Y motion up to the start of byte 1, gathered since byte 5 of the last report started.
// - motion toward the cord gives positive Y.
// - byte 4 is X motion gathered since byte 1 started.
// - byte 5 is Y motion gathered since byte 4 started.
`timescale 1ns/1ns
`include "mouse_report_defines.vh"
module mouse_motion_report_serializer #(
	parameter BIT_CYC = `BIT_CYCLES
) (
	input wire ref_clk,
	input wire rst,
	input wire sw_left_pressed,
	input wire sw_middle_pressed,
	input wire sw_right_pressed,
	input wire x_step,
	input wire x_right,
	input wire y_step,
	input wire y_toward_cord,
	output reg serial_out,
	output reg report_busy
);
	localparam [5:0] ST_IDLE = 6'h01;
	localparam [5:0] ST_B1 = 6'h02;
	localparam [5:0] ST_B2 = 6'h04;
	localparam [5:0] ST_B3 = 6'h08;
	localparam [5:0] ST_B4 = 6'h10;
	localparam [5:0] ST_B5 = 6'h20;

	// saturating add of one step, clamped at +/-127
	function [7:0] sat_step;
		input [7:0] acc;
		input up;
		begin
			if (up)
				sat_step = (acc == `DELTA_MAX) ? acc : acc + 8'h01;
			else
				sat_step = (acc == `DELTA_MIN) ? acc : acc - 8'h01;
		end
	endfunction

	reg [5:0] state_reg;
	reg [7:0] x_acc_reg;
	reg [7:0] y_acc_reg;
	reg [2:0] sw_sent_reg;
	reg [7:0] x2_reg;
	reg [7:0] y3_reg;
	reg [2:0] sw_cap_reg;
	// two-entry buffer between builder and transmitter
	reg [7:0] buf_data_reg [0:1];
	reg buf_wr_reg;
	reg buf_rd_reg;
	reg [1:0] buf_cnt_reg;
	reg push;
	reg [7:0] push_data;

	wire [2:0] sw_now = {~sw_left_pressed, ~sw_middle_pressed, ~sw_right_pressed};
	wire [7:0] x_inc = x_step ? sat_step(x_acc_reg, x_right) : x_acc_reg;
	wire [7:0] y_inc = y_step ? sat_step(y_acc_reg, y_toward_cord) : y_acc_reg;
	wire changed = (sw_now != sw_sent_reg) || (x_acc_reg != 8'h00) || (y_acc_reg != 8'h00);
	wire buf_full = (buf_cnt_reg == 2'h2);
	wire buf_valid = (buf_cnt_reg != 2'h0);
	wire tx_ready;
	wire tx_line;
	wire pop = buf_valid && tx_ready;
	// empty buffer and waiting transmitter: a byte pushed now is written on the next edge and starts on the edge after
	wire tx_idle = !buf_valid && tx_ready;
	// a step in the capture cycle opens the new interval, so no count is lost
	wire [7:0] x_restart = x_step ? sat_step(8'h00, x_right) : 8'h00;
	wire [7:0] y_restart = y_step ? sat_step(8'h00, y_toward_cord) : 8'h00;

	always @* begin
		push = 1'b0;
		push_data = 8'h00;
		case (state_reg)
			ST_B1: begin
				push = tx_idle;
				push_data = {`SYNC_PATTERN, sw_cap_reg};
			end
			ST_B2: begin
				push = !buf_full;
				push_data = x2_reg;
			end
			ST_B3: begin
				push = !buf_full;
				push_data = y3_reg;
			end
			ST_B4: begin
				push = tx_idle;
				push_data = x_acc_reg;
			end
			ST_B5: begin
				push = tx_idle;
				push_data = y_acc_reg;
			end
			default: begin
				push = 1'b0;
			end
		endcase
	end

	always @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			buf_data_reg[0] <= 8'h00;
			buf_data_reg[1] <= 8'h00;
			buf_wr_reg <= 1'b0;
			buf_rd_reg <= 1'b0;
			buf_cnt_reg <= 2'h0;
		end else begin
			if (push) begin
				buf_data_reg[buf_wr_reg] <= push_data;
				buf_wr_reg <= ~buf_wr_reg;
			end
			if (pop)
				buf_rd_reg <= ~buf_rd_reg;
			if (push && !pop)
				buf_cnt_reg <= buf_cnt_reg + 2'h1;
			else if (pop && !push)
				buf_cnt_reg <= buf_cnt_reg - 2'h1;
		end
	end

	// bytes 1, 4 and 5 are pushed only into an idle transmitter, so each capture sits one edge
	// before that byte's start bit; y motion between the byte 1 and byte 4 starts is dropped
	always @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			state_reg <= ST_IDLE;
			x_acc_reg <= 8'h00;
			y_acc_reg <= 8'h00;
			sw_sent_reg <= 3'h7;
			sw_cap_reg <= 3'h7;
			x2_reg <= 8'h00;
			y3_reg <= 8'h00;
			report_busy <= 1'b0;
		end else begin
			x_acc_reg <= x_inc;
			y_acc_reg <= y_inc;
			case (state_reg)
				ST_IDLE: begin
					report_busy <= 1'b0;
					// waiting for an idle line keeps the five bytes of one report together
					if (changed && tx_idle) begin
						state_reg <= ST_B1;
						report_busy <= 1'b1;
						sw_cap_reg <= sw_now;
						sw_sent_reg <= sw_now;
					end
				end
				ST_B1: begin
					if (push) begin
						x2_reg <= x_acc_reg;
						y3_reg <= y_acc_reg;
						x_acc_reg <= x_restart;
						y_acc_reg <= y_restart;
						state_reg <= ST_B2;
					end
				end
				ST_B2: begin
					if (push) begin
						state_reg <= ST_B3;
					end
				end
				ST_B3: begin
					if (push) begin
						state_reg <= ST_B4;
					end
				end
				ST_B4: begin
					// the next edge opens the byte 5 interval, one edge before byte 4 starts
					if (push) begin
						x_acc_reg <= x_restart;
						y_acc_reg <= y_restart;
						state_reg <= ST_B5;
					end
				end
				ST_B5: begin
					if (push) begin
						y_acc_reg <= y_restart;
						report_busy <= 1'b0;
						state_reg <= ST_IDLE;
					end
				end
				default: begin
					state_reg <= ST_IDLE;
				end
			endcase
		end
	end

	uart_byte_tx #(
		.BIT_CYC(BIT_CYC)
	) tx_unit (
		.ref_clk(ref_clk),
		.rst(rst),
		.tx_data(buf_data_reg[buf_rd_reg]),
		.tx_valid(buf_valid),
		.tx_ready(tx_ready),
		.tx_start(),
		.serial_out(tx_line)
	);

	always @(posedge ref_clk or posedge rst) begin
		if (rst)
			serial_out <= 1'b1;
		else
			serial_out <= tx_line;
	end
endmodule

// File: mouse_report_props.sv
// checker for the motion report serializer ports
`timescale 1ns/1ns
`include "mouse_report_defines.vh"
module mouse_report_props #(
	parameter BIT_CYC = `BIT_CYCLES
) (
	input wire ref_clk,
	input wire rst,
	input wire x_step,
	input wire y_step,
	input wire serial_out,
	input wire report_busy
);
	logic [16:0] low_run;
	logic [16:0] high_run;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);
	sequence go_soon; ##[1:4] report_busy; endsequence
	// two bit times of high line do not exclude high data bits or byte 1's bit 7 plus stop bit, so the transmitter may still be busy
	always @(posedge ref_clk) begin
		low_run <= (rst || serial_out) ? 17'h00000 : low_run + 17'h00001;
		high_run <= (rst || !serial_out) ? 17'h00000 : (high_run[16] ? high_run : high_run + 17'h00001);
	end
	a_bit_width: assert property ($rose(serial_out) |-> low_run >= BIT_CYC - 1) else $error("bit short");
	a_stop_bit: assert property (low_run <= 9 * BIT_CYC + 1) else $error("no stop bit");
	a_start_run: assert property ($fell(serial_out) |-> !serial_out [*8]) else $error("glitch");
	a_busy_line: assert property ($rose(report_busy) |-> ##[1:8] !serial_out) else $error("no start");
	a_busy_hold: assert property ($rose(report_busy) |-> report_busy [*8]) else $error("busy drop");
	a_x_report: assert property (!report_busy && x_step && high_run >= 2 * BIT_CYC |-> go_soon)
		else $error("no x report");
	a_y_report: assert property (!report_busy && y_step && high_run >= 2 * BIT_CYC |-> go_soon)
		else $error("no y report");
	a_reset_idle: assert property ($fell(rst) |-> serial_out && !report_busy) else $error("not idle");
endmodule
bind mouse_motion_report_serializer mouse_report_props #(.BIT_CYC(BIT_CYC)) u_props (.ref_clk, .rst, .x_step,
	.y_step, .serial_out, .report_busy);

// File: mux_rx.sv
// serial receiver model for the multiplexer input port
`timescale 1ns/1ns
`include "mouse_report_defines.vh"
module mux_rx #(
	parameter int BIT_CYC = `BIT_CYCLES
) (
	input wire ref_clk,
	input wire serial_in,
	output logic [7:0] rx_byte = 8'h00,
	output logic rx_strobe = 1'b0
);
	initial begin
		forever begin
			@(negedge serial_in);
			repeat (BIT_CYC / 2) @(posedge ref_clk);
			for (int i = 0; i < 8; i++) begin
				repeat (BIT_CYC) @(posedge ref_clk);
				rx_byte[i] <= serial_in;
			end
			repeat (BIT_CYC) @(posedge ref_clk);
			// a missing stop bit gives no strobe, so the bench times out
			rx_strobe <= serial_in;
			@(posedge ref_clk);
			rx_strobe <= 1'b0;
		end
	end
endmodule

// File: mouse_motion_report_serializer_tb.sv
// bench for the motion report serializer
`timescale 1ns/1ns
`include "mouse_report_defines.vh"
module mouse_motion_report_serializer_tb;
	struct {logic [2:0] sw; logic xr; int nx; logic yt; int ny; logic [7:0] ex, ey;} rows[3] = '{
		'{3'h4, 1, 5, 0, 3, 8'h05, 8'hFD}, '{3'h2, 0, 200, 1, 130, 8'h81, 8'h7F}, '{3'h1, 1, 127, 0, 128, 8'h7F, 8'h81}};
	logic ref_clk = 0, rst = 1, xs = 0, xr = 0, ys = 0, yt = 0;
	logic [2:0] sw = 3'h0;
	wire serial_out, report_busy, rx_strobe;
	wire [7:0] rx_byte;
	int n_errors = 0, checks = 0, cycles = 0, r, k, t;
	// a short bit time keeps the run small; the divider logic is the same at any length
	localparam int BIT = 32;
	mouse_motion_report_serializer #(.BIT_CYC(BIT)) u_dut (.ref_clk, .rst, .sw_left_pressed(sw[2]),
		.sw_middle_pressed(sw[1]), .sw_right_pressed(sw[0]), .x_step(xs), .x_right(xr), .y_step(ys),
		.y_toward_cord(yt), .serial_out, .report_busy);
	mux_rx #(.BIT_CYC(BIT)) u_rx (.ref_clk, .serial_in(serial_out), .rx_byte, .rx_strobe);
	initial begin
		forever #5 ref_clk = ~ref_clk;
	end
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 20000) begin
			n_errors++;
			end_of_test();
		end
	end
	task end_of_test();
		$display("checks %0d errors %0d", checks, n_errors);
		if (n_errors == 0 && checks > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	task chk(input string s, input logic [7:0] exp, seen);
		checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("wrong value %s expected %h seen %h", s, exp, seen);
		end
	endtask
	// each byte must land within twelve bit times, else the run is cut short
	task get(input logic [7:0] exp);
		t = 0;
		do begin
			@(posedge ref_clk);
			t++;
		end while (rx_strobe !== 1'b1 && t < 12 * BIT);
		if (t == 12 * BIT) begin
			n_errors++;
			end_of_test();
		end else
			chk("report byte", exp, rx_byte);
	endtask
	initial begin
		repeat (4) @(posedge ref_clk);
		chk("reset state", 8'h01, {6'h00, report_busy, serial_out});
		rst <= 0;
		for (r = 0; r < 3; r++) begin
			@(posedge ref_clk);
			sw <= rows[r].sw;
			xr <= rows[r].xr;
			yt <= rows[r].yt;
			// x motion lands after byte 1 starts and before byte 4, so it belongs to byte 4
			repeat (20) @(posedge ref_clk);
			for (k = 0; k <= 200; k++) begin
				@(posedge ref_clk);
				xs <= k < rows[r].nx;
			end
			get({5'h10, ~rows[r].sw});
			repeat (2) get(8'h00);
			// y motion waits for the byte 4 start bit, so it belongs to byte 5
			@(negedge serial_out);
			for (k = 0; k <= 130; k++) begin
				@(posedge ref_clk);
				ys <= k < rows[r].ny;
			end
			get(rows[r].ex);
			get(rows[r].ey);
			repeat (BIT) @(posedge ref_clk);
		end
		repeat (3 * BIT) @(posedge ref_clk);
		chk("quiet line", 8'h01, {6'h00, report_busy, serial_out});
		xr <= 0;
		yt <= 1;
		xs <= 1;
		ys <= 1;
		@(posedge ref_clk);
		xs <= 0;
		ys <= 0;
		get({5'h10, ~sw});
		get(8'hFF);
		get(8'h01);
		repeat (2) get(8'h00);
		end_of_test();
	end
endmodule
